/* File: rps_cfg.svh */
// constants for the reset pin sequencer: offsets, field positions, reset values
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH

`define RPS_ADDR_W           4
`define RPS_OFS_FLAG_CTRL    4'h0
`define RPS_OFS_PBUS_CTRL    4'h1
`define RPS_OFS_XBUS_CTRL    4'h2
`define RPS_OFS_STATUS       4'h3
`define RPS_OFS_VECTOR       4'h4

`define RPS_FLAG0_DIR_BIT    1
`define RPS_FLAG0_OUT_BIT    2
`define RPS_FLAG0_IN_BIT     3
`define RPS_FLAG1_DIR_BIT    5
`define RPS_FLAG1_OUT_BIT    6
`define RPS_FLAG1_IN_BIT     7

`define RPS_WS_W             3
`define RPS_WS_LSB           0
`define RPS_WS_RESET         3'h7

`define RPS_ST_IN_RESET      0
`define RPS_ST_HOLD_ACK      1
`define RPS_ST_BOOT_DONE     2
`define RPS_ST_MC_MODE       3
`define RPS_ST_FETCH_IDX     4

`define RPS_VEC_ADDR         24'h000000
`define RPS_VEC_W            24
`define RPS_PERIPH_PINS      14

// pin control word in reset: every enable off, strobes, rw and acknowledges high
`define RPS_CTL_RESET        14'h03d6

`endif

/* File: rps_ext_model.sv */
// external reset source, hold requester and memory holding the reset vector
module rps_ext_model #(
  parameter logic [23:0] VEC = 24'h5a3c01
) (
  input  wire logic        i_clk,
  input  wire logic [23:0] i_addr,
  input  wire logic        i_addr_oe,
  input  wire logic        i_primary_bus_strobe_n,
  input  wire logic        i_rw,
  input  wire logic [31:0] i_data,
  input  wire logic        i_data_oe,
  output logic             o_rst_pin_n,
  output logic             o_hold_n,
  output logic [31:0]      o_data_in
);
  logic [31:0] last_q = 32'h0;
  initial begin
    o_rst_pin_n = 1'b0;
    o_hold_n = 1'b1;
  end
  // a released bus toggles every cycle so a stale value is never mistaken for data
  always_comb begin
    if (i_data_oe)
      o_data_in = i_data;
    else if (!i_primary_bus_strobe_n && i_rw && i_addr_oe && i_addr == 24'h0)
      o_data_in = {8'ha5, VEC};
    else
      o_data_in = ~last_q;
  end
  always_ff @(posedge i_clk) last_q <= o_data_in;
  task automatic pulse_reset(input int n);
    int k;
    k = (n < 10) ? 10 : n;
    @(posedge i_clk);
    o_rst_pin_n <= 1'b0;
    repeat (k) @(posedge i_clk);
    o_rst_pin_n <= 1'b1;
  endtask : pulse_reset
  task automatic set_hold(input logic v);
    @(posedge i_clk);
    o_hold_n <= v;
  endtask : set_hold
endmodule : rps_ext_model

/* File: rps_pkg.sv */
// types shared by the reset pin sequencer modules
package rps_pkg;
  typedef enum logic [1:0] {
    RPS_FETCH_IDLE   = 2'b00,
    RPS_FETCH_ACCESS = 2'b01,
    RPS_FETCH_DONE   = 2'b10
  } rps_fetch_state_type;
endpackage : rps_pkg

/* File: rps_sync.sv */
// two-stage synchroniser for asynchronous level inputs
module rps_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = meta_q;
    sync_d = sync_q;
    if (!i_resetn) begin
      meta_d = RESET_VAL;
      sync_d = RESET_VAL;
    end else if (i_ce) begin
      meta_d = i_async;
      sync_d = meta_q;
    end
  end

  always_ff @(posedge i_clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign o_sync = sync_q;
endmodule : rps_sync

/* File: rps_top.sv */
// reset pin sequencer: reset intake, pin floating, bus defaults, vector fetch, flag pins
`include "rps_cfg.svh"
module rps_top
  import rps_pkg::*;
#(
  parameter int VEC_W = `RPS_VEC_W
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_resetn,
  input  wire logic                       i_ce,
  input  wire logic                       i_rst_pin_n,
  input  wire logic                       i_hold_n,
  input  wire logic                       i_mcmode,
  input  wire logic [`RPS_ADDR_W-1:0]     i_addr,
  input  wire logic [31:0]                i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [31:0]                o_rdata,
  input  wire logic [1:0]                 i_flag_in,
  output logic      [1:0]                 o_flag_out,
  output logic      [1:0]                 o_flag_oe,
  input  wire logic [`RPS_PERIPH_PINS-1:0] i_periph_oe,
  output logic      [`RPS_PERIPH_PINS-1:0] o_periph_oe,
  input  wire logic [23:0]                i_core_addr,
  input  wire logic                       i_core_primary_bus_strobe,
  input  wire logic                       i_core_wr,
  input  wire logic [31:0]                i_core_wdata,
  input  wire logic [12:0]                i_core_xaddr,
  input  wire logic                       i_core_expansion_memory_strobe,
  input  wire logic                       i_core_expansion_io_strobe,
  input  wire logic                       i_core_xwr,
  input  wire logic [31:0]                i_core_xwdata,
  input  wire logic                       i_core_interrupt_acknowledge_out,
  input  wire logic [31:0]                i_data_in,
  input  wire logic [VEC_W-1:0]           i_rom_vector,
  output logic      [23:0]                o_addr,
  output logic                            o_addr_oe,
  output logic      [12:0]                o_xaddr,
  output logic                            o_xaddr_oe,
  output logic      [31:0]                o_data,
  output logic                            o_data_oe,
  output logic      [31:0]                o_xdata,
  output logic                            o_xdata_oe,
  output logic                            o_primary_bus_strobe_n,
  output logic                            o_expansion_memory_strobe_n,
  output logic                            o_expansion_io_strobe_n,
  output logic                            o_rw,
  output logic                            o_rw_oe,
  output logic                            o_xrw,
  output logic                            o_xrw_oe,
  output logic                            o_interrupt_acknowledge_out_n,
  output logic                            o_holda_n,
  output logic                            o_boot_done,
  output logic      [VEC_W-1:0]           o_vector
);
  import rps_pkg::*;

  // synchronised versions of the asynchronous pins
  logic       rst_pin_sync_n;
  logic       hold_sync_n;
  logic       rst_active;
  logic       hold_active;
  logic       float_q;
  logic       float_d;

  rps_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_rst_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_async  (i_rst_pin_n),
    .o_sync   (rst_pin_sync_n)
  );

  rps_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_hold_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_async  (i_hold_n),
    .o_sync   (hold_sync_n)
  );

  assign rst_active  = !rst_pin_sync_n;
  // hold is not gated by reset, so a hold request wins even while reset is low
  assign hold_active = !hold_sync_n;

  // the pin float path skips the synchroniser to answer the pin within one cycle
  always_comb begin
    float_d = float_q;
    if (!i_resetn) begin
      float_d = 1'b1;
    end else if (i_ce) begin
      float_d = !i_rst_pin_n;
    end
  end

  always_ff @(posedge i_clk) begin
    float_q <= float_d;
  end

  // software registers
  logic [1:0]           dir_q;
  logic [1:0]           dir_d;
  logic [1:0]           outv_q;
  logic [1:0]           outv_d;
  logic [1:0]           inv_q;
  logic [1:0]           inv_d;
  logic [`RPS_WS_W-1:0] pws_q;
  logic [`RPS_WS_W-1:0] pws_d;
  logic [`RPS_WS_W-1:0] xws_q;
  logic [`RPS_WS_W-1:0] xws_d;
  logic [31:0]          rdata_q;
  logic [31:0]          rdata_d;
  logic [31:0]          flag_word;
  logic [31:0]          status_word;
  logic                 fetch_busy;
  logic                 fetch_done;
  logic                 fetch_idx;
  logic [VEC_W-1:0]     fetch_vec;
  logic [VEC_W-1:0]     boot_data;
  logic                 sw_reset;

  assign sw_reset = !i_resetn || rst_active;

  always_comb begin
    flag_word = 32'h0;
    flag_word[`RPS_FLAG0_DIR_BIT] = dir_q[0];
    flag_word[`RPS_FLAG0_OUT_BIT] = outv_q[0];
    flag_word[`RPS_FLAG0_IN_BIT]  = inv_q[0];
    flag_word[`RPS_FLAG1_DIR_BIT] = dir_q[1];
    flag_word[`RPS_FLAG1_OUT_BIT] = outv_q[1];
    flag_word[`RPS_FLAG1_IN_BIT]  = inv_q[1];
    status_word = 32'h0;
    status_word[`RPS_ST_IN_RESET]  = rst_active;
    status_word[`RPS_ST_HOLD_ACK]  = hold_active;
    status_word[`RPS_ST_BOOT_DONE] = fetch_done;
    status_word[`RPS_ST_MC_MODE]   = i_mcmode;
    status_word[`RPS_ST_FETCH_IDX] = fetch_idx;
  end

  always_comb begin
    dir_d   = dir_q;
    outv_d  = outv_q;
    inv_d   = inv_q;
    pws_d   = pws_q;
    xws_d   = xws_q;
    rdata_d = 32'h0;
    if (sw_reset) begin
      dir_d  = 2'h0;
      outv_d = 2'h0;
      inv_d  = 2'h0;
      pws_d  = `RPS_WS_RESET;
      xws_d  = `RPS_WS_RESET;
    end else if (i_ce) begin
      // input value bits follow the pin only while the flag is an input
      if (!dir_q[0]) begin
        inv_d[0] = i_flag_in[0];
      end
      if (!dir_q[1]) begin
        inv_d[1] = i_flag_in[1];
      end
      if (i_wr) begin
        case (i_addr)
          `RPS_OFS_FLAG_CTRL: begin
            dir_d[0]  = i_wdata[`RPS_FLAG0_DIR_BIT];
            dir_d[1]  = i_wdata[`RPS_FLAG1_DIR_BIT];
            outv_d[0] = i_wdata[`RPS_FLAG0_OUT_BIT];
            outv_d[1] = i_wdata[`RPS_FLAG1_OUT_BIT];
          end
          `RPS_OFS_PBUS_CTRL: begin
            pws_d = i_wdata[`RPS_WS_LSB +: `RPS_WS_W];
          end
          `RPS_OFS_XBUS_CTRL: begin
            xws_d = i_wdata[`RPS_WS_LSB +: `RPS_WS_W];
          end
          default: begin
          end
        endcase
      end
      if (i_rd) begin
        case (i_addr)
          `RPS_OFS_FLAG_CTRL: rdata_d = flag_word;
          `RPS_OFS_PBUS_CTRL: rdata_d = {{(32-`RPS_WS_W){1'b0}}, pws_q};
          `RPS_OFS_XBUS_CTRL: rdata_d = {{(32-`RPS_WS_W){1'b0}}, xws_q};
          `RPS_OFS_STATUS:    rdata_d = status_word;
          `RPS_OFS_VECTOR:    rdata_d = {{(32-VEC_W){1'b0}}, fetch_vec};
          default:            rdata_d = 32'h0;
        endcase
      end
    end else begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge i_clk) begin
    dir_q   <= dir_d;
    outv_q  <= outv_d;
    inv_q   <= inv_d;
    pws_q   <= pws_d;
    xws_q   <= xws_d;
    rdata_q <= rdata_d;
  end

  // vector fetch: rom in microcomputer mode, external data bus otherwise
  assign boot_data = i_mcmode ? i_rom_vector : i_data_in[VEC_W-1:0];

  rps_vec_fetch #(
    .VEC_W (VEC_W)
  ) u_fetch (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_ce        (i_ce),
    .i_restart   (rst_active),
    .i_run       (!hold_active),
    .i_mcmode    (i_mcmode),
    .i_waits     (pws_q),
    .i_data      (boot_data),
    .o_busy      (fetch_busy),
    .o_done      (fetch_done),
    .o_fetch_idx (fetch_idx),
    .o_vector    (fetch_vec)
  );

  // pin stage: every pin output is a flip-flop
  logic                        quiet;
  logic                        ext_fetch;
  logic [23:0]                 addr_d;
  logic [23:0]                 addr_q;
  logic [12:0]                 xaddr_d;
  logic [12:0]                 xaddr_q;
  logic [31:0]                 data_d;
  logic [31:0]                 data_q;
  logic [31:0]                 xdata_d;
  logic [31:0]                 xdata_q;
  logic [1:0]                  fout_d;
  logic [1:0]                  fout_q;
  logic [1:0]                  foe_d;
  logic [1:0]                  foe_q;
  logic [`RPS_PERIPH_PINS-1:0] poe_d;
  logic [`RPS_PERIPH_PINS-1:0] poe_q;
  logic [13:0]                 ctl_d;
  logic [13:0]                 ctl_q;
  logic [VEC_W-1:0]            vec_out_d;
  logic [VEC_W-1:0]            vec_out_q;

  // core strobes, rw and data enables reach the pins only after both vector fetches; i_core_addr is used whenever ext_fetch is low
  assign quiet     = sw_reset || float_q;
  assign ext_fetch = fetch_busy && !i_mcmode;

  // ctl bit order: addr_oe xaddr_oe data_oe xdata_oe primary_bus_strobe_n expansion_memory_strobe_n expansion_io_strobe_n
  //                rw rw_oe xrw xrw_oe interrupt_acknowledge_out_n holda_n boot_done
  always_comb begin
    addr_d    = addr_q;
    xaddr_d   = xaddr_q;
    data_d    = data_q;
    xdata_d   = xdata_q;
    fout_d    = fout_q;
    foe_d     = foe_q;
    poe_d     = poe_q;
    ctl_d     = ctl_q;
    vec_out_d = vec_out_q;
    if (!i_resetn) begin
      addr_d    = 24'h0;
      xaddr_d   = 13'h0;
      data_d    = 32'h0;
      xdata_d   = 32'h0;
      fout_d    = 2'h0;
      foe_d     = 2'h0;
      poe_d     = '0;
      ctl_d     = `RPS_CTL_RESET;
      vec_out_d = '0;
    end else if (i_ce) begin
      addr_d    = ext_fetch ? `RPS_VEC_ADDR : i_core_addr;
      xaddr_d   = i_core_xaddr;
      data_d    = i_core_wdata;
      xdata_d   = i_core_xwdata;
      vec_out_d = fetch_vec;
      fout_d    = outv_q;
      foe_d     = (quiet || float_d) ? 2'h0 : dir_q;
      poe_d     = (quiet || float_d) ? '0 : i_periph_oe;
      if (quiet || float_d || hold_active) begin
        ctl_d[13] = 1'b0;
        ctl_d[12] = 1'b0;
        ctl_d[11] = 1'b0;
        ctl_d[10] = 1'b0;
        ctl_d[9]  = 1'b1;
        ctl_d[8]  = 1'b1;
        ctl_d[7]  = 1'b1;
        ctl_d[6]  = 1'b1;
        ctl_d[5]  = 1'b0;
        ctl_d[4]  = 1'b1;
        ctl_d[3]  = 1'b0;
        ctl_d[2]  = 1'b1;
      end else if (!fetch_done) begin
        ctl_d[13] = 1'b1;
        ctl_d[12] = 1'b0;
        ctl_d[11] = 1'b0;
        ctl_d[10] = 1'b0;
        ctl_d[9]  = !ext_fetch;
        ctl_d[8]  = 1'b1;
        ctl_d[7]  = 1'b1;
        ctl_d[6]  = 1'b1;
        ctl_d[5]  = 1'b1;
        ctl_d[4]  = 1'b1;
        ctl_d[3]  = 1'b1;
        ctl_d[2]  = 1'b1;
      end else begin
        ctl_d[13] = 1'b1;
        ctl_d[12] = 1'b1;
        ctl_d[11] = i_core_wr;
        ctl_d[10] = i_core_xwr;
        ctl_d[9]  = !i_core_primary_bus_strobe;
        ctl_d[8]  = !i_core_expansion_memory_strobe;
        ctl_d[7]  = !i_core_expansion_io_strobe;
        ctl_d[6]  = !i_core_wr;
        ctl_d[5]  = 1'b1;
        ctl_d[4]  = !i_core_xwr;
        ctl_d[3]  = 1'b1;
        ctl_d[2]  = !i_core_interrupt_acknowledge_out;
      end
      ctl_d[1] = !hold_active;
      ctl_d[0] = fetch_done && !quiet;
    end
  end

  always_ff @(posedge i_clk) begin
    addr_q    <= addr_d;
    xaddr_q   <= xaddr_d;
    data_q    <= data_d;
    xdata_q   <= xdata_d;
    fout_q    <= fout_d;
    foe_q     <= foe_d;
    poe_q     <= poe_d;
    ctl_q     <= ctl_d;
    vec_out_q <= vec_out_d;
  end

  assign o_rdata     = rdata_q;
  assign o_flag_out  = fout_q;
  assign o_flag_oe   = foe_q;
  assign o_periph_oe = poe_q;
  assign o_addr      = addr_q;
  assign o_xaddr     = xaddr_q;
  assign o_data      = data_q;
  assign o_xdata     = xdata_q;
  assign o_vector    = vec_out_q;
  assign o_addr_oe   = ctl_q[13];
  assign o_xaddr_oe  = ctl_q[12];
  assign o_data_oe   = ctl_q[11];
  assign o_xdata_oe  = ctl_q[10];
  assign o_primary_bus_strobe_n    = ctl_q[9];
  assign o_expansion_memory_strobe_n   = ctl_q[8];
  assign o_expansion_io_strobe_n  = ctl_q[7];
  assign o_rw        = ctl_q[6];
  assign o_rw_oe     = ctl_q[5];
  assign o_xrw       = ctl_q[4];
  assign o_xrw_oe    = ctl_q[3];
  assign o_interrupt_acknowledge_out_n    = ctl_q[2];
  assign o_holda_n   = ctl_q[1];
  assign o_boot_done = ctl_q[0];
endmodule : rps_top

/* File: rps_top_chk.sv */
// concurrent checks on the reset pin sequencer ports
`include "rps_cfg.svh"
module rps_top_chk (
  input  wire logic                        i_clk,
  input  wire logic                        i_resetn,
  input  wire logic                        i_rst_pin_n,
  input  wire logic                        i_hold_n,
  input  wire logic                        i_mcmode,
  input  wire logic [1:0]                  o_flag_oe,
  input  wire logic [`RPS_PERIPH_PINS-1:0] o_periph_oe,
  input  wire logic [23:0]                 o_addr,
  input  wire logic                        o_addr_oe,
  input  wire logic                        o_xaddr_oe,
  input  wire logic                        o_data_oe,
  input  wire logic                        o_xdata_oe,
  input  wire logic                        o_primary_bus_strobe_n,
  input  wire logic                        o_expansion_memory_strobe_n,
  input  wire logic                        o_expansion_io_strobe_n,
  input  wire logic                        o_rw_oe,
  input  wire logic                        o_xrw_oe,
  input  wire logic                        o_interrupt_acknowledge_out_n,
  input  wire logic                        o_holda_n,
  input  wire logic                        o_boot_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // four samples cover the two-flop sync, the output flop and one late cycle
  a_bus_float: assert property ((!i_rst_pin_n) [*4] |->
    !(o_addr_oe || o_xaddr_oe || o_data_oe || o_xdata_oe)) else $error("bus driven in reset");
  a_async_float: assert property ((!i_rst_pin_n) [*3] |->
    o_flag_oe == 2'h0 && o_periph_oe == 14'h0) else $error("flag or port pins driven in reset");
  a_ctl_inactive: assert property ((!i_rst_pin_n) [*4] |->
    o_primary_bus_strobe_n && o_expansion_memory_strobe_n && o_expansion_io_strobe_n) else $error("strobe active in reset");
  a_ack_inactive: assert property ((!i_rst_pin_n) [*4] |-> o_interrupt_acknowledge_out_n)
    else $error("acknowledge active in reset");
  a_rw_float: assert property ((!i_rst_pin_n) [*4] |-> !o_rw_oe && !o_xrw_oe)
    else $error("direction output driven in reset");
  a_hold_honoured: assert property ((!i_hold_n) [*5] |-> !o_holda_n)
    else $error("hold not acknowledged");
  a_mp_boot_time: assert property ($rose(i_rst_pin_n) && !i_mcmode |=>
    (!o_boot_done) [*8] ##1 (!o_boot_done) [*7] ##[1:15] o_boot_done)
    else $error("slow boot timing wrong");
  a_mc_boot_time: assert property ($rose(i_rst_pin_n) && i_mcmode |->
    ##[3:12] o_boot_done) else $error("fast boot timing wrong");
  a_fetch_addr: assert property (!o_primary_bus_strobe_n && !o_boot_done |->
    o_addr_oe && o_addr == `RPS_VEC_ADDR) else $error("fetch address wrong");
endmodule : rps_top_chk

/* File: rps_vec_fetch.sv */
// double reset-vector fetch sequencer with software wait-state counting
`include "rps_cfg.svh"
module rps_vec_fetch
  import rps_pkg::*;
#(
  parameter int VEC_W = `RPS_VEC_W
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_ce,
  input  wire logic                 i_restart,
  input  wire logic                 i_run,
  input  wire logic                 i_mcmode,
  input  wire logic [`RPS_WS_W-1:0] i_waits,
  input  wire logic [VEC_W-1:0]     i_data,
  output logic                      o_busy,
  output logic                      o_done,
  output logic                      o_fetch_idx,
  output logic      [VEC_W-1:0]     o_vector
);
  rps_fetch_state_type state_q;
  rps_fetch_state_type state_d;
  logic [`RPS_WS_W-1:0] count_q;
  logic [`RPS_WS_W-1:0] count_d;
  logic                 idx_q;
  logic                 idx_d;
  logic [VEC_W-1:0]     vec_q;
  logic [VEC_W-1:0]     vec_d;
  logic [`RPS_WS_W-1:0] load_ws;

  // internal rom needs no software wait states
  assign load_ws = i_mcmode ? '0 : i_waits;

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    idx_d   = idx_q;
    vec_d   = vec_q;
    if (!i_resetn || i_restart) begin
      state_d = RPS_FETCH_IDLE;
      count_d = '0;
      idx_d   = 1'b0;
      vec_d   = '0;
    end else if (i_ce && i_run) begin
      case (state_q)
        RPS_FETCH_IDLE: begin
          state_d = RPS_FETCH_ACCESS;
          count_d = load_ws;
        end
        RPS_FETCH_ACCESS: begin
          if (count_q == '0) begin
            vec_d = i_data;
            if (idx_q) begin
              state_d = RPS_FETCH_DONE;
            end else begin
              // second fetch of the same vector, same wait count
              idx_d   = 1'b1;
              count_d = load_ws;
            end
          end else begin
            count_d = count_q - 1'b1;
          end
        end
        RPS_FETCH_DONE: begin
          state_d = RPS_FETCH_DONE;
        end
        default: begin
          state_d = RPS_FETCH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    state_q <= state_d;
    count_q <= count_d;
    idx_q   <= idx_d;
    vec_q   <= vec_d;
  end

  assign o_busy      = (state_q == RPS_FETCH_ACCESS);
  assign o_done      = (state_q == RPS_FETCH_DONE);
  assign o_fetch_idx = idx_q;
  assign o_vector    = vec_q;
endmodule : rps_vec_fetch

/* File: tb_top.sv */
// self-checking bench for the reset pin sequencer
`include "rps_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] VEC_MP = 24'h5a3c01;
  localparam logic [23:0] VEC_MC = 24'h00c3e5;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_ce = 1'b1, i_mcmode = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic i_core_primary_bus_strobe = 1'b0, i_core_wr = 1'b0, i_core_expansion_memory_strobe = 1'b0, i_core_expansion_io_strobe = 1'b0;
  logic i_core_xwr = 1'b0, i_core_interrupt_acknowledge_out = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [1:0] i_flag_in = 2'h0;
  logic [`RPS_PERIPH_PINS-1:0] i_periph_oe = 14'h0;
  logic [23:0] i_core_addr = 24'h0, i_rom_vector = 24'h0;
  logic [12:0] i_core_xaddr = 13'h0;
  logic [31:0] i_wdata = 32'h0, i_core_wdata = 32'h0, i_core_xwdata = 32'h0;
  logic i_rst_pin_n, i_hold_n, o_addr_oe, o_xaddr_oe, o_data_oe, o_xdata_oe, o_primary_bus_strobe_n;
  logic o_expansion_memory_strobe_n, o_expansion_io_strobe_n, o_rw, o_rw_oe, o_xrw, o_xrw_oe, o_interrupt_acknowledge_out_n, o_holda_n, o_boot_done;
  logic [1:0] o_flag_out, o_flag_oe;
  logic [`RPS_PERIPH_PINS-1:0] o_periph_oe;
  logic [23:0] o_addr, o_vector;
  logic [12:0] o_xaddr;
  logic [31:0] o_rdata, o_data, o_xdata, i_data_in;
  int bad_count = 0, n_tests = 0, cyc = 0, primary_bus_strobe_lo = 0;

  rps_top u_rps_top (.*);
  rps_ext_model #(.VEC(VEC_MP)) u_rps_ext_model (.i_clk(i_clk), .i_addr(o_addr),
    .i_addr_oe(o_addr_oe), .i_primary_bus_strobe_n(o_primary_bus_strobe_n), .i_rw(o_rw), .i_data(o_data),
    .i_data_oe(o_data_oe), .o_rst_pin_n(i_rst_pin_n), .o_hold_n(i_hold_n),
    .o_data_in(i_data_in));

  always #20 i_clk = ~i_clk;
  // fetch strobe cycles are counted here; the ceiling is far above the three boots
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (!o_primary_bus_strobe_n && !o_boot_done)
      primary_bus_strobe_lo <= primary_bus_strobe_lo + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report;
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    repeat (2) @(negedge i_clk);
  endtask : wr
  task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp,
                       input logic [31:0] m);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(what, exp & m, o_rdata & m);
  endtask : rdchk
  task automatic boot(input int n, input logic [31:0] strobes);
    int k;
    primary_bus_strobe_lo = 0;
    u_rps_ext_model.pulse_reset(n);
    {i_core_primary_bus_strobe, i_core_wr, i_core_expansion_memory_strobe, i_core_expansion_io_strobe, i_core_xwr, i_core_interrupt_acknowledge_out} <= 6'h0;
    k = 0;
    while (o_boot_done !== 1'b1 && k < 100) begin
      @(negedge i_clk);
      k++;
    end
    chk("boot done", 32'h1, {31'h0, o_boot_done});
    chk("fetch strobe cycles", strobes, primary_bus_strobe_lo);
  endtask : boot

  initial begin
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    i_periph_oe <= 14'h3fff;
    // core requests stay pending through the pin reset; nothing may reach the pins
    {i_core_primary_bus_strobe, i_core_wr, i_core_expansion_memory_strobe, i_core_expansion_io_strobe, i_core_xwr, i_core_interrupt_acknowledge_out} <= 6'h3f;
    i_core_addr <= 24'hffffff;
    i_core_xaddr <= 13'h1fff;
    boot(12, 32'h10);
    rdchk("vector mp", `RPS_OFS_VECTOR, {8'h0, VEC_MP}, 32'hffffff);
    rdchk("primary waits", `RPS_OFS_PBUS_CTRL, 32'h7, 32'h7);
    rdchk("expansion waits", `RPS_OFS_XBUS_CTRL, 32'h7, 32'h7);
    rdchk("unmapped", 4'hf, 32'h0, 32'hffffffff);
    chk("port pins", 32'h3fff, {18'h0, o_periph_oe});
    chk("vector pins", {8'h0, VEC_MP}, {8'h0, o_vector});
    chk("expansion address pins", 32'h1fff, {19'h0, o_xaddr});
    $display("test boot_mp done");
    wr(`RPS_OFS_PBUS_CTRL, 32'h3);
    wr(`RPS_OFS_XBUS_CTRL, 32'h2);
    rdchk("primary waits set", `RPS_OFS_PBUS_CTRL, 32'h3, 32'h7);
    fork
      boot(14, 32'h10);
      begin
        repeat (3) @(posedge i_clk);
        u_rps_ext_model.set_hold(1'b0);
        repeat (6) @(negedge i_clk);
        chk("hold ack in reset", 32'h0, {31'h0, o_holda_n});
        u_rps_ext_model.set_hold(1'b1);
      end
    join
    rdchk("primary waits reload", `RPS_OFS_PBUS_CTRL, 32'h7, 32'h7);
    rdchk("expansion waits reload", `RPS_OFS_XBUS_CTRL, 32'h7, 32'h7);
    $display("test reload_hold done");
    i_mcmode <= 1'b1;
    i_rom_vector <= VEC_MC;
    boot(10, 32'h0);
    rdchk("vector mc", `RPS_OFS_VECTOR, {8'h0, VEC_MC}, 32'hffffff);
    rdchk("status", `RPS_OFS_STATUS, 32'h1c, 32'h1f);
    $display("test boot_mc done");
    i_flag_in <= 2'b10;
    wr(`RPS_OFS_FLAG_CTRL, 32'h6);
    chk("flag enables", 32'h1, {30'h0, o_flag_oe});
    chk("flag0 level", 32'h1, {31'h0, o_flag_out[0]});
    rdchk("flag ctrl a", `RPS_OFS_FLAG_CTRL, 32'h86, 32'he6);
    i_flag_in <= 2'b01;
    wr(`RPS_OFS_FLAG_CTRL, 32'h60);
    chk("flag enables b", 32'h2, {30'h0, o_flag_oe});
    chk("flag1 level", 32'h1, {31'h0, o_flag_out[1]});
    rdchk("flag ctrl b", `RPS_OFS_FLAG_CTRL, 32'h68, 32'h6e);
    $display("test flags done");
    final_report;
  end
endmodule : tb_top

bind rps_top rps_top_chk u_rps_top_chk (.*);
